// ===== bench/dgr_host_model.sv
// Host controller model that runs 24-bit serial register frames.
// Assumes the mclk of the device; its serial clock stands still between frames.
`timescale 1ns/100ps
module dgr_host_model (
	input wire logic mclk,
	output logic spiCsN,
	output logic spiSclk,
	output logic spiSdi,
	input wire logic spiSdo,
	input wire logic spiSdoOe
);
	// Mclk cycles per serial clock phase, above the three the device needs
	localparam int Phase = 5;
	// Idle levels: deselected, clock low
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiSdi = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// serial register access
	// One frame, MSB first; read data taken before each rise
	task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [23:0] frame;
		frame = {rd, 7'h00, addr, wdata};
		rdata = 8'h00;
		spiCsN <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiSdi <= frame[i];
			repeat (Phase) @(posedge mclk);
			// Data bits only count while the device drives the line
			if (i < 8) begin
				rdata[i] = spiSdo & spiSdoOe;
			end
			spiSclk <= 1'b1;
			repeat (Phase) @(posedge mclk);
			spiSclk <= 1'b0;
		end
		repeat (Phase) @(posedge mclk);
		spiCsN <= 1'b1;
		// Released data line shows the inverse of its last bit
		spiSdi <= ~frame[0];
		repeat (Phase) @(posedge mclk);
	endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the range and clamp controller.
// Assumes the host model drives the serial pins; bench drives the rest.
`timescale 1ns/100ps
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic alarmEvent = 1'b0;
	logic [3:0] supplyBelowTh = 4'h0;
	logic spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe, dataDefaultLoad;
	logic [7:0] groupRange;
	logic [3:0] groupClampNeg;
	logic [15:0] chanClamp, chanPowerDown;
	int numErrors = 0;
	int nChecks = 0;
	int cycles = 0;
	// Clock at 250 MHz
	always #2 mclk = ~mclk;
	dgr_range_clamp_ctrl dgr_range_clamp_ctrl_i (.mclk(mclk), .rst(rst), .spiCsN(spiCsN),
		.spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
		.supplyBelowTh(supplyBelowTh), .alarmEvent(alarmEvent), .groupRange(groupRange),
		.groupClampNeg(groupClampNeg), .chanClamp(chanClamp), .chanPowerDown(chanPowerDown),
		.dataDefaultLoad(dataDefaultLoad));
	dgr_host_model dgr_host_model_i (.mclk(mclk), .spiCsN(spiCsN), .spiSclk(spiSclk),
		.spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe));
	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic giveVerdict();
		if (numErrors == 0 && nChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			giveVerdict();
		end
	end
	// Expected range per group from comparator levels
	function automatic logic [15:0] expRange(input logic [3:0] below);
		logic [15:0] r;
		r = 16'h0000;
		for (int g = 0; g < 4; g++) begin
			r[2*g +: 2] = below[g] ? dgr_pkg::RangeNeg10 : dgr_pkg::RangePos5;
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////
	// Register access, with time for any detection to finish
	task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		dgr_host_model_i.xfer(1'b0, addr, data, unused);
		repeat (20) @(posedge mclk);
	endtask
	task automatic regRead(input logic [7:0] addr, input logic [15:0] exp);
		logic [7:0] d;
		dgr_host_model_i.xfer(1'b1, addr, 8'h00, d);
		check(16'(d), exp);
	endtask
	////////////////////////////////////////////////////////////////
	// Reset, clamp and default load, then detection
	task automatic doReset(input logic [3:0] below);
		supplyBelowTh <= below;
		rst <= 1'b1;
		@(posedge mclk);
		#1;
		check(chanClamp, 16'hffff);
		check(16'(dataDefaultLoad), 16'h0001);
		@(posedge mclk);
		rst <= 1'b0;
		repeat (16) @(posedge mclk);
		check(16'(groupRange), expRange(below));
		check(16'(groupClampNeg), 16'(below));
		check(chanClamp, 16'hffff);
		check(16'(dataDefaultLoad), 16'h0000);
		regRead(8'h72, {8'h00, 4'hf, below});
	endtask
	// Software ranges, all four codes, positive range on a negative clamp
	task automatic testOverride();
		regWrite(8'h1e, 8'h31);
		regWrite(8'h1f, 8'h02);
		check(16'(groupRange), 16'h002d);
		check(16'(groupClampNeg), 16'h0005);
		regRead(8'h1e, 16'h0031);
		regRead(8'h1f, 16'h0002);
	endtask
	// Each trigger register reruns detection; levels alone change nothing
	task automatic testRedetect();
		logic [7:0] offs [3] = '{8'hb2, 8'hb3, 8'h02};
		logic [7:0] vals [3] = '{8'h0f, 8'h80, 8'h00};
		logic [3:0] pats [3] = '{4'b1010, 4'b0011, 4'b1100};
		logic [3:0] held;
		held = groupClampNeg;
		for (int k = 0; k < 3; k++) begin
			supplyBelowTh <= pats[k];
			repeat (20) @(posedge mclk);
			check(16'(groupClampNeg), 16'(held));
			regWrite(offs[k], vals[k]);
			check(16'(groupRange), expRange(pats[k]));
			held = pats[k];
		end
		check(chanPowerDown, 16'h800f);
	endtask
	// Release, then alarm clamp only when enabled
	task automatic testAlarm();
		alarmEvent <= 1'b1;
		regWrite(8'h02, 8'h02);
		check(chanClamp, 16'h0000);
		regWrite(8'h02, 8'h01);
		check(chanClamp, 16'hffff);
		regRead(8'h02, 16'h0001);
		alarmEvent <= 1'b0;
		regWrite(8'h02, 8'h02);
		check(chanClamp, 16'h0000);
		regRead(8'h72, 16'h000c);
	endtask
	// Read-only status and unmapped place
	task automatic testRefused();
		regWrite(8'h72, 8'hff);
		regRead(8'h72, 16'h000c);
		regRead(8'h40, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence, ending with a reset in mid-run
	initial begin
		doReset(4'b0101);
		testOverride();
		testRedetect();
		testAlarm();
		testRefused();
		doReset(4'b1001);
		giveVerdict();
	end
endmodule

// ===== hw/dgr_detect_if.sv
// Carrier between the controller and its auto-range detector.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface dgr_detect_if;
	logic trigger; // One-cycle request to run detection
	logic [3:0] belowSync; // Synchronised comparator levels per group
	logic [3:0] detectNeg; // Captured result, high means negative supply
	logic done; // One-cycle pulse when result is captured
	modport ctrl (output trigger, output belowSync, input detectNeg, input done);
	modport det (input trigger, input belowSync, output detectNeg, output done);
endinterface

// ===== hw/dgr_pkg.sv
// Constants for the DAC group range and clamp controller.
// Assumes a single 250 MHz clock and a 24-bit serial register frame.
// Contract
// - Sixteen channels form four groups of four.
// - Each group shares one range, one clamp.
// - Reset drives all outputs to clamp value.
// - Reset returns DAC data to defaults.
// - Supply below threshold selects minus ten range.
// - Supply above threshold selects plus five range.
// - Detection results readable in general status.
// - Power-down or config writes rerun detection.
// - Software range writes apply to any group.
// - Optional automatic clamp on alarm event.
// - Clamp value follows supply pin, not range.
// - Positive range allowed with negative clamp.
package dgr_pkg;
	localparam int NumGroups = 4;
	localparam int ChanPerGroup = 4;
	localparam int NumChan = 16;
	localparam int RangeW = 2;
	// Register offsets
	localparam logic [7:0] OffDevCfg = 8'h02;
	localparam logic [7:0] OffRangeLow = 8'h1e;
	localparam logic [7:0] OffRangeHigh = 8'h1f;
	localparam logic [7:0] OffGenStatus = 8'h72;
	localparam logic [7:0] OffPowerDownLow = 8'hb2;
	localparam logic [7:0] OffPowerDownHigh = 8'hb3;
	// Range codes
	localparam logic [1:0] RangePos5 = 2'h0;
	localparam logic [1:0] RangePos10 = 2'h1;
	localparam logic [1:0] RangeNeg5 = 2'h2;
	localparam logic [1:0] RangeNeg10 = 2'h3;
	// Device configuration fields
	localparam int CfgAlarmClampBit = 0;
	localparam int CfgClampReleaseBit = 1;
	localparam logic [7:0] CfgReset = 8'h00;
	localparam logic [7:0] CfgStoreMask = 8'hfd;
	// Reset values
	localparam logic [15:0] PowerDownReset = 16'h0000;
	localparam logic [3:0] ClampReset = 4'hf;
	localparam logic [7:0] RangeReset = 8'h00;
	// Serial frame layout
	localparam int FrameBits = 24;
	localparam int ReadFlagBit = 23;
	localparam int AddrMsb = 15;
	localparam int AddrLsb = 8;
	localparam logic [4:0] CntAddrDone = 5'h0f;
	localparam logic [4:0] CntDataStart = 5'h10;
	localparam logic [4:0] CntLast = 5'h17;
	// Comparator settle time before a detection result is taken
	localparam int SettleNs = 16;
	localparam int SettleCycles = (SettleNs + 3) / 4;
	localparam int CntW = 4;
endpackage

// ===== hw/dgr_range_clamp_ctrl.sv
// Top of the DAC group range and clamp controller with serial register port.
// Assumes asynchronous serial pins, comparator levels and alarm from outside.
`timescale 1ns/100ps
module dgr_range_clamp_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOe,
	input wire logic [3:0] supplyBelowTh,
	input wire logic alarmEvent,
	output logic [7:0] groupRange,
	output logic [3:0] groupClampNeg,
	output logic [15:0] chanClamp,
	output logic [15:0] chanPowerDown,
	output logic dataDefaultLoad
);
	localparam int DetLatMax = 10; // Trigger to done, worst case

	dgr_detect_if det ();

	dgr_range_detect #(
		.Settle(dgr_pkg::SettleCycles)
	) u_detect (
		.mclk(mclk),
		.rst(rst),
		.det(det.det)
	);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [7:0] meta1Q; // First stage, read only by second stage
	logic [7:0] meta2Q; // Second stage
	logic [1:0] prevQ; // History of chip select and serial clock
	logic csActive, sclkRise, sclkFall, alarmSync;

	// Two flip-flops per asynchronous input
	always_ff @(posedge mclk) begin
		if (rst) begin
			// Idle pin levels: deselected, serial clock low, so no false edge
			meta1Q <= 8'h01;
			meta2Q <= 8'h01;
			prevQ <= 2'h1;
		end else begin
			meta1Q <= {alarmEvent, supplyBelowTh, spiSdi, spiSclk, spiCsN};
			meta2Q <= meta1Q;
			prevQ <= meta2Q[1:0];
		end
	end

	assign csActive = ~meta2Q[0];
	assign sclkRise = meta2Q[1] & ~prevQ[1];
	assign sclkFall = ~meta2Q[1] & prevQ[1];
	assign alarmSync = meta2Q[7];
	assign det.belowSync = meta2Q[6:3];

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] cfgQ, cfgD; // Device configuration
	logic [7:0] rangeQ, rangeD; // Two bits per group
	logic [15:0] pdQ, pdD; // Power-down per channel
	logic [3:0] statusQ, statusD; // Detected negative supply per group
	logic [3:0] clampQ, clampD; // Clamp active per group
	logic initQ; // High in reset and one cycle after
	logic wrQ, wrD; // One-cycle register write strobe
	logic [7:0] wrAddrQ, wrAddrD; // Write address
	logic [7:0] wrDataQ, wrDataD; // Write data

	// Read data mux; unmapped offsets read zero
	function automatic logic [7:0] readData(input logic [7:0] addr);
		logic [7:0] r;
		r = 8'h00;
		unique case (addr)
			dgr_pkg::OffDevCfg: r = cfgQ;
			dgr_pkg::OffRangeLow: r = {2'h0, rangeQ[3:2], 2'h0, rangeQ[1:0]};
			dgr_pkg::OffRangeHigh: r = {2'h0, rangeQ[7:6], 2'h0, rangeQ[5:4]};
			dgr_pkg::OffGenStatus: r = {clampQ, statusQ};
			dgr_pkg::OffPowerDownLow: r = pdQ[7:0];
			dgr_pkg::OffPowerDownHigh: r = pdQ[15:8];
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Serial frame engine
	logic [23:0] shQ, shD; // Incoming bits
	logic [4:0] cntQ, cntD; // Bits received in frame
	logic [7:0] txQ, txD; // Outgoing read data
	logic sdoQ, sdoD; // Registered serial output

	// Shift in on rising serial clock, out on falling
	always_comb begin
		shD = shQ;
		cntD = cntQ;
		txD = txQ;
		sdoD = sdoQ;
		wrD = 1'b0;
		wrAddrD = wrAddrQ;
		wrDataD = wrDataQ;
		if (!csActive) begin
			// Idle frame resets the bit count
			cntD = 5'h00;
			sdoD = 1'b0;
		end else if (sclkRise) begin
			shD = {shQ[22:0], meta2Q[2]};
			if (cntQ != 5'h1f) begin
				cntD = cntQ + 5'h01;
			end
			// Address complete: fetch read data
			if (cntQ == dgr_pkg::CntAddrDone) begin
				// Only sixteen bits are in, so the address still sits at the bottom
				txD = readData(shD[dgr_pkg::AddrMsb - dgr_pkg::AddrLsb:0]);
			end
			// Last bit of a write frame commits it
			if (cntQ == dgr_pkg::CntLast && !shD[dgr_pkg::ReadFlagBit]) begin
				wrD = 1'b1;
				wrAddrD = shD[dgr_pkg::AddrMsb:dgr_pkg::AddrLsb];
				wrDataD = shD[7:0];
			end
		end else if (sclkFall && cntQ >= dgr_pkg::CntDataStart && cntQ <= dgr_pkg::CntLast) begin
			// Present read data MSB first
			sdoD = txQ[7];
			txD = {txQ[6:0], 1'b0};
		end
	end

	// Frame registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			shQ <= 24'h000000;
			cntQ <= 5'h00;
			txQ <= 8'h00;
			sdoQ <= 1'b0;
			wrQ <= 1'b0;
			wrAddrQ <= 8'h00;
			wrDataQ <= 8'h00;
		end else begin
			shQ <= shD;
			cntQ <= cntD;
			txQ <= txD;
			sdoQ <= sdoD;
			wrQ <= wrD;
			wrAddrQ <= wrAddrD;
			wrDataQ <= wrDataD;
		end
	end

	assign spiSdo = sdoQ;
	assign spiSdoOe = csActive;

	////////////////////////////////////////////////////////////////////////
	// Register file, detection trigger and clamp control
	logic wrTrig;

	// power-down or config writes rerun detection
	assign wrTrig = wrQ && (wrAddrQ == dgr_pkg::OffDevCfg
		|| wrAddrQ == dgr_pkg::OffPowerDownLow || wrAddrQ == dgr_pkg::OffPowerDownHigh);
	assign det.trigger = wrTrig | initQ;

	// Next register values
	always_comb begin
		cfgD = cfgQ;
		rangeD = rangeQ;
		pdD = pdQ;
		statusD = statusQ;
		clampD = clampQ;
		// results change only on detector completion
		if (det.done) begin
			statusD = det.detectNeg;
			for (int g = 0; g < dgr_pkg::NumGroups; g++) begin
				rangeD[2*g +: 2] = det.detectNeg[g] ? dgr_pkg::RangeNeg10 : dgr_pkg::RangePos5;
			end
		end
		if (wrQ) begin
			unique case (wrAddrQ)
				dgr_pkg::OffDevCfg: begin
					cfgD = wrDataQ & dgr_pkg::CfgStoreMask;
					if (wrDataQ[dgr_pkg::CfgClampReleaseBit]) begin
						clampD = 4'h0;
					end
				end
				// software range applies to any group
				dgr_pkg::OffRangeLow: rangeD[3:0] = {wrDataQ[5:4], wrDataQ[1:0]};
				dgr_pkg::OffRangeHigh: rangeD[7:4] = {wrDataQ[5:4], wrDataQ[1:0]};
				dgr_pkg::OffPowerDownLow: pdD[7:0] = wrDataQ;
				dgr_pkg::OffPowerDownHigh: pdD[15:8] = wrDataQ;
				default: ;
			endcase
		end
		// alarm forces clamp; set wins over release
		if (cfgQ[dgr_pkg::CfgAlarmClampBit] && alarmSync) begin
			clampD = 4'hf;
		end
	end

	// reset clamps outputs and loads data defaults
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfgQ <= dgr_pkg::CfgReset;
			rangeQ <= dgr_pkg::RangeReset;
			pdQ <= dgr_pkg::PowerDownReset;
			statusQ <= 4'h0;
			clampQ <= dgr_pkg::ClampReset;
			initQ <= 1'b1;
		end else begin
			cfgQ <= cfgD;
			rangeQ <= rangeD;
			pdQ <= pdD;
			statusQ <= statusD;
			clampQ <= clampD;
			initQ <= 1'b0;
		end
	end

	for (genvar c = 0; c < dgr_pkg::NumChan; c++) begin : g_chan
		assign chanClamp[c] = clampQ[c / dgr_pkg::ChanPerGroup];
	end

	assign groupRange = rangeQ;
	// clamp polarity from supply pin only
	assign groupClampNeg = statusQ;
	assign chanPowerDown = pdQ;
	assign dataDefaultLoad = initQ;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// All checks run on mclk and stand down while reset is held;
	// the reset checks override that on their own line
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence pdWrite;
		wrQ && wrAddrQ == dgr_pkg::OffPowerDownLow;
	endsequence
	sequence detDone;
		det.done ##1 statusQ == $past(det.detectNeg);
	endsequence
	sequence cfgWrite;
		wrQ && wrAddrQ == dgr_pkg::OffDevCfg;
	endsequence
	sequence resetRelease;
		rst ##1 !rst;
	endsequence

	// Reset forces clamp and data default load
	reset_clamp_a: assert property (@(posedge mclk) disable iff (1'b0)
		rst |=> clampQ == 4'hf && dataDefaultLoad) else $error("clamp not set by reset");
	// Channels of a group follow its clamp
	group_share_a: assert property (chanClamp[3:0] == {4{clampQ[0]}}
		&& chanClamp[15:12] == {4{clampQ[3]}}) else $error("channel clamp not per group");
	// Default load lasts one cycle past reset
	data_default_a: assert property (@(posedge mclk) disable iff (1'b0)
		rst ##1 !rst |-> dataDefaultLoad ##1 !dataDefaultLoad) else $error("default load");
	// Negative supply picks the minus ten range
	range_neg_a: assert property (det.done && det.detectNeg[1] && !wrQ
		|=> groupRange[3:2] == dgr_pkg::RangeNeg10) else $error("negative range not set");
	// Positive supply picks the plus five range
	range_pos_a: assert property (det.done && !det.detectNeg[2] && !wrQ
		|=> groupRange[5:4] == dgr_pkg::RangePos5) else $error("positive range not set");
	// Result lands in status one cycle after done
	status_rec_a: assert property (det.done |-> detDone) else $error("status not stored");
	// Low power-down writes rerun detection
	rerun_det_a: assert property (pdWrite |-> ##[1:DetLatMax] det.done)
		else $error("detection not rerun");
	// Configuration writes rerun detection
	cfg_rerun_a: assert property (cfgWrite |-> ##[1:DetLatMax] det.done)
		else $error("config write did not rerun detection");
	// Reset release runs detection
	reset_det_a: assert property (@(posedge mclk) disable iff (1'b0)
		resetRelease |-> ##[1:DetLatMax] det.done) else $error("no detection after reset");
	// Software range writes land for group 3
	sw_range_a: assert property (wrQ && wrAddrQ == dgr_pkg::OffRangeHigh && !det.done
		|=> groupRange[7:6] == $past(wrDataQ[5:4])) else $error("range write lost");
	// Software range writes land for group 0
	range_low_a: assert property (wrQ && wrAddrQ == dgr_pkg::OffRangeLow && !det.done
		|=> groupRange[1:0] == $past(wrDataQ[1:0])) else $error("low range write lost");
	// Enabled alarm clamps every group
	alarm_clamp_a: assert property (cfgQ[0] && alarmSync |=> clampQ == 4'hf)
		else $error("alarm did not clamp");
	// Release bit clears clamps when no alarm forces them
	clamp_release_a: assert property (wrQ && wrAddrQ == dgr_pkg::OffDevCfg
		&& wrDataQ[dgr_pkg::CfgClampReleaseBit] && !(cfgQ[dgr_pkg::CfgAlarmClampBit] && alarmSync)
		|=> clampQ == 4'h0) else $error("clamp release lost");
	// Clamps stay until software releases them
	clamp_hold_a: assert property (clampQ == 4'hf
		&& !(wrQ && wrAddrQ == dgr_pkg::OffDevCfg) |=> clampQ == 4'hf)
		else $error("clamp dropped without release");
	// Low range writes leave clamp polarity alone
	clamp_indep_a: assert property (wrQ && wrAddrQ == dgr_pkg::OffRangeLow && !det.done
		|=> $stable(groupClampNeg)) else $error("clamp followed range");
	// Clamp polarity moves only on detection
	clamp_neg_a: assert property (!det.done |=> $stable(groupClampNeg))
		else $error("clamp polarity changed without detection");
	// Results move only on completion
	hold_result_a: assert property (!det.done |=> $stable(statusQ))
		else $error("result changed without detection");
	// Status ignores host writes
	status_ro_a: assert property (wrQ && wrAddrQ == dgr_pkg::OffGenStatus && !det.done
		|=> $stable(statusQ)) else $error("status changed by host write");
endmodule

// ===== hw/dgr_range_detect.sv
// Auto-range detector: waits for comparators to settle, then captures.
// Assumes synchronised comparator inputs and a one-cycle trigger.
`timescale 1ns/100ps
module dgr_range_detect #(
	parameter int Settle = dgr_pkg::SettleCycles
) (
	input wire logic mclk,
	input wire logic rst,
	dgr_detect_if.det det
);
	typedef enum logic [1:0] {DetIdle, DetSettle, DetCapture} dgr_det_state_t;

	dgr_det_state_t state_q, state_d; // Detector sequence
	logic [dgr_pkg::CntW-1:0] cnt_q, cnt_d; // Settle counter
	logic [3:0] resQ, resD; // Held result
	logic doneQ, doneD; // Completion pulse

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		resD = resQ;
		doneD = 1'b0;
		unique case (state_q)
			DetIdle: begin
				// A new trigger starts the settle wait from zero
				if (det.trigger) begin
					state_d = DetSettle;
					cnt_d = '0;
				end
			end
			DetSettle: begin
				// Retrigger restarts the wait
				if (det.trigger) begin
					cnt_d = '0;
				end else if (cnt_q == dgr_pkg::CntW'(Settle - 1)) begin
					state_d = DetCapture;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			DetCapture: begin
				resD = det.belowSync;
				doneD = 1'b1;
				state_d = det.trigger ? DetSettle : DetIdle;
				cnt_d = '0;
			end
		endcase
	end

	// Registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= DetIdle;
			cnt_q <= '0;
			resQ <= 4'h0;
			doneQ <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			resQ <= resD;
			doneQ <= doneD;
		end
	end

	assign det.detectNeg = resQ;
	assign det.done = doneQ;

	done_pulse_a: assert property (@(posedge mclk) disable iff (rst)
		doneQ |=> !doneQ) else $error("detection done held high");
endmodule
